/* File: service_status_pkg.sv */
/*
 * Shared constants for the service-access and status indicator block:
 * register map, field layout, reset values, timing and status modes.
 * Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package service_status_pkg;

	localparam int CLK_HZ = 25_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int LINK_TOGGLE_MS = 1000;
	localparam int CMD_TOGGLE_MS = 500;
	localparam int FAULT_TOGGLE_MS = 250;
	localparam int TX_TOGGLE_MS = 50;
	localparam int LINK_TOGGLE_CYC = LINK_TOGGLE_MS * CYC_PER_MS;
	localparam int CMD_TOGGLE_CYC = CMD_TOGGLE_MS * CYC_PER_MS;
	localparam int FAULT_TOGGLE_CYC = FAULT_TOGGLE_MS * CYC_PER_MS;
	localparam int TX_TOGGLE_CYC = TX_TOGGLE_MS * CYC_PER_MS;

	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_CFG = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_HOP_PEND = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_HOP_ACT = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_LIVE = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_FAULT = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STS = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h20;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// serial format and command-enable field layout
	localparam int CFG_W = 8;
	localparam int FMT_W = 7;
	localparam int BAUD_LSB = 0;
	localparam int BAUD_W = 3;
	localparam int DATA8_BIT = 3;
	localparam int PAR_LSB = 4;
	localparam int PAR_W = 2;
	localparam int STOP2_BIT = 6;
	localparam int CMD_BIT = 7;
	localparam logic [BAUD_W-1:0] BAUD_38400 = 3'h4;
	localparam logic [FMT_W-1:0] FMT_FORCED = 7'h0C;
	localparam logic [CFG_W-1:0] CFG_RST = 8'h8A;

	localparam int CTRL_REBOOT_BIT = 0;
	localparam int FAULT_CODE_W = 8;
	localparam logic [31:0] HOP_RST = 32'h0000_0000;

	localparam int IRQ_W = 4;
	localparam int IRQ_SVC_ON = 0;
	localparam int IRQ_SVC_OFF = 1;
	localparam int IRQ_FAULT = 2;
	localparam int IRQ_APPLY = 3;

	localparam int N_BLINK = 4;
	localparam int BL_TX = 0;
	localparam int BL_LINK = 1;
	localparam int BL_CMD = 2;
	localparam int BL_FAULT = 3;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RX = 3'h1,
		ST_SLEEP = 3'h3,
		ST_TX = 3'h2,
		ST_LINK = 3'h6,
		ST_CMD = 3'h7,
		ST_FAULT = 3'h5
	} stat_mode_t;

endpackage

/* File: blink_toggler.sv */
/*
 * Square-wave source for one status pattern: inverts its output once per
 * half_cyc clock cycles while run is high, rests high while run is low.
 * Assumes a single free-running clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
module blink_toggler #(
	parameter int HALF_CYC = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	output logic wave
);
	localparam int CNT_W = $clog2(HALF_CYC + 1);

	if (HALF_CYC < 1) begin : g_chk
		$error("blink_toggler: HALF_CYC must be at least 1");
	end

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic wave;
	} blink_state_t;

	blink_state_t s_ff;
	blink_state_t nxt_s;

	always_comb begin
		nxt_s = s_ff;
		if (!run) begin
			nxt_s.cnt = '0;
			nxt_s.wave = 1'b1;
		end else if (s_ff.cnt == CNT_W'(HALF_CYC - 1)) begin
			nxt_s.cnt = '0;
			nxt_s.wave = !s_ff.wave;
		end else begin
			nxt_s.cnt = s_ff.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= '{cnt: '0, wave: 1'b1};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign wave = s_ff.wave;

endmodule // blink_toggler

/* File: service_mode_status_indicator.sv */
/*
 * Service-access override of the primary serial port format, status
 * indicator pattern generation, deferred band-parameter apply, and an
 * AXI4-Lite register slave with a sticky interrupt status.
 * Assumes all status inputs and service_n are synchronous to aclk; the
 * pull-up on the service pin sits in the pad ring.
 */
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module service_mode_status_indicator
	import service_status_pkg::*;
#(
	parameter int HOP_W = 32,
	parameter int LINK_CYC = LINK_TOGGLE_CYC,
	parameter int CMD_CYC = CMD_TOGGLE_CYC,
	parameter int FAULT_CYC = FAULT_TOGGLE_CYC,
	parameter int TX_CYC = TX_TOGGLE_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic service_n,
	input wire logic rx_frame,
	input wire logic tx_active,
	input wire logic low_power_state_one,
	input wire logic cfg_link,
	input wire logic cmd_mode,
	input wire logic fault_active,
	input wire logic [FAULT_CODE_W-1:0] fault_code,
	output logic [BAUD_W-1:0] primary_serial_port_baud,
	output logic primary_serial_port_data8,
	output logic [PAR_W-1:0] primary_serial_port_parity,
	output logic primary_serial_port_stop2,
	output logic text_config_commands_en,
	output logic [HOP_W-1:0] hop_active,
	output logic status_out,
	output logic irq
);

	if (HOP_W < 1 || HOP_W > 32) begin : g_chk_hop
		$error("service_mode_status_indicator: HOP_W must be 1..32");
	end
	if (LINK_CYC < 1 || CMD_CYC < 1 || FAULT_CYC < 1 || TX_CYC < 1) begin : g_chk_cyc
		$error("service_mode_status_indicator: toggle counts must be at least 1");
	end

	typedef struct packed {
		logic [CFG_W-1:0] cfg;
		logic [HOP_W-1:0] pend;
		logic [HOP_W-1:0] act;
		logic [IRQ_W-1:0] sts;
		logic [IRQ_W-1:0] en;
		logic irq;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic svc_prev;
		logic cmd_prev;
		logic flt_prev;
		logic [FMT_W-1:0] live;
		logic cmds_en;
		stat_mode_t mode;
		logic stat;
	} state_t;

	state_t s_ff;
	state_t nxt_s;
	logic [N_BLINK-1:0] blink_run;
	logic [N_BLINK-1:0] blink_wave;

	localparam int BLINK_CYC [N_BLINK] = '{TX_CYC, LINK_CYC, CMD_CYC, FAULT_CYC};

	function automatic logic [31:0] merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0] strb
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction

	// patterns run only while their mode is shown, so each starts at a full interval
	assign blink_run[BL_TX] = (s_ff.mode == ST_TX);
	assign blink_run[BL_LINK] = (s_ff.mode == ST_LINK);
	assign blink_run[BL_CMD] = (s_ff.mode == ST_CMD);
	assign blink_run[BL_FAULT] = (s_ff.mode == ST_FAULT);

	for (genvar g = 0; g < N_BLINK; g++) begin : g_blink
		blink_toggler #(
			.HALF_CYC(BLINK_CYC[g])
		) u_blink (
			.aclk(aclk),
			.aresetn(aresetn),
			.run(blink_run[g]),
			.wave(blink_wave[g])
		);
	end

	always_comb begin
		logic svc_on;
		logic reboot;
		logic apply;
		logic [IRQ_W-1:0] set_v;
		logic [IRQ_W-1:0] clr_v;
		logic [31:0] pend_w;
		svc_on = !service_n;
		reboot = 1'b0;
		apply = 1'b0;
		set_v = '0;
		clr_v = '0;
		pend_w = '0;
		nxt_s = s_ff;

		if (s_ff.bvalid && bready) begin
			nxt_s.bvalid = 1'b0;
		end
		if (s_ff.rvalid && rready) begin
			nxt_s.rvalid = 1'b0;
		end
		if (awvalid && awready) begin
			nxt_s.aw_got = 1'b1;
			nxt_s.awaddr = awaddr;
		end
		if (wvalid && wready) begin
			nxt_s.w_got = 1'b1;
			nxt_s.wdata = wdata;
			nxt_s.wstrb = wstrb;
		end

		// write commits once both address and data are held
		if (s_ff.aw_got && s_ff.w_got) begin
			nxt_s.aw_got = 1'b0;
			nxt_s.w_got = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = RESP_OKAY;
			case (s_ff.awaddr)
				OFF_CFG: begin
					if (s_ff.wstrb[0]) begin
						nxt_s.cfg = s_ff.wdata[CFG_W-1:0];
					end
				end
				OFF_HOP_PEND: begin
					pend_w = merge(32'(s_ff.pend), s_ff.wdata, s_ff.wstrb);
					nxt_s.pend = pend_w[HOP_W-1:0];
				end
				OFF_CTRL: begin
					reboot = s_ff.wstrb[0] && s_ff.wdata[CTRL_REBOOT_BIT];
				end
				OFF_IRQ_CLR: begin
					if (s_ff.wstrb[0]) begin
						clr_v = s_ff.wdata[IRQ_W-1:0];
					end
				end
				OFF_IRQ_EN: begin
					if (s_ff.wstrb[0]) begin
						nxt_s.en = s_ff.wdata[IRQ_W-1:0];
					end
				end
				OFF_HOP_ACT, OFF_LIVE, OFF_FAULT, OFF_IRQ_STS: begin
					nxt_s.bresp = RESP_OKAY;
				end
				default: begin
					nxt_s.bresp = RESP_SLVERR;
				end
			endcase
		end

		if (arvalid && arready) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp = RESP_OKAY;
			nxt_s.rdata = '0;
			case (araddr)
				OFF_CFG: nxt_s.rdata = 32'(s_ff.cfg);
				OFF_HOP_PEND: nxt_s.rdata = 32'(s_ff.pend);
				OFF_HOP_ACT: nxt_s.rdata = 32'(s_ff.act);
				OFF_CTRL: nxt_s.rdata = '0;
				OFF_LIVE: nxt_s.rdata = 32'({s_ff.cmds_en, s_ff.live});
				OFF_FAULT: nxt_s.rdata = 32'(fault_code);
				OFF_IRQ_STS: nxt_s.rdata = 32'(s_ff.sts);
				OFF_IRQ_CLR: nxt_s.rdata = '0;
				OFF_IRQ_EN: nxt_s.rdata = 32'(s_ff.en);
				default: begin
					nxt_s.rresp = RESP_SLVERR;
				end
			endcase
		end

		// new band parameters go live only on reboot or command mode exit
		apply = reboot || (s_ff.cmd_prev && !cmd_mode);
		if (apply) begin
			nxt_s.act = s_ff.pend;
		end

		nxt_s.svc_prev = svc_on;
		nxt_s.cmd_prev = cmd_mode;
		nxt_s.flt_prev = fault_active;
		set_v[IRQ_SVC_ON] = svc_on && !s_ff.svc_prev;
		set_v[IRQ_SVC_OFF] = !svc_on && s_ff.svc_prev;
		set_v[IRQ_FAULT] = fault_active && !s_ff.flt_prev;
		set_v[IRQ_APPLY] = apply;
		// a new event wins over a clear in the same cycle
		nxt_s.sts = (s_ff.sts & ~clr_v) | set_v;
		nxt_s.irq = |(nxt_s.sts & nxt_s.en);

		// override touches only the live format, never the stored cfg
		if (svc_on) begin
			nxt_s.live = FMT_FORCED;
		end else begin
			nxt_s.live = s_ff.cfg[FMT_W-1:0];
		end
		// command mode also forces text commands on
		nxt_s.cmds_en = s_ff.cfg[CMD_BIT] || svc_on || cmd_mode;

		if (fault_active) begin
			nxt_s.mode = ST_FAULT;
		end else if (cmd_mode && !s_ff.cfg[CMD_BIT]) begin
			nxt_s.mode = ST_CMD;
		end else if (cfg_link) begin
			nxt_s.mode = ST_LINK;
		end else if (tx_active) begin
			nxt_s.mode = ST_TX;
		end else if (rx_frame) begin
			nxt_s.mode = ST_RX;
		end else if (low_power_state_one) begin
			nxt_s.mode = ST_SLEEP;
		end else begin
			nxt_s.mode = ST_IDLE;
		end

		case (s_ff.mode)
			ST_IDLE: nxt_s.stat = 1'b1;
			ST_RX: nxt_s.stat = 1'b0;
			ST_SLEEP: nxt_s.stat = 1'b0;
			ST_TX: nxt_s.stat = blink_wave[BL_TX];
			ST_LINK: nxt_s.stat = blink_wave[BL_LINK];
			ST_CMD: nxt_s.stat = blink_wave[BL_CMD];
			ST_FAULT: nxt_s.stat = blink_wave[BL_FAULT];
			default: nxt_s.stat = 1'b1;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= '{
				cfg: CFG_RST,
				pend: HOP_W'(HOP_RST),
				act: HOP_W'(HOP_RST),
				sts: '0,
				en: '0,
				irq: 1'b0,
				aw_got: 1'b0,
				w_got: 1'b0,
				awaddr: '0,
				wdata: '0,
				wstrb: '0,
				bvalid: 1'b0,
				bresp: RESP_OKAY,
				rvalid: 1'b0,
				rresp: RESP_OKAY,
				rdata: '0,
				svc_prev: 1'b0,
				cmd_prev: 1'b0,
				flt_prev: 1'b0,
				live: CFG_RST[FMT_W-1:0],
				cmds_en: CFG_RST[CMD_BIT],
				mode: ST_IDLE,
				stat: 1'b1
			};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign awready = !s_ff.aw_got && !s_ff.bvalid;
	assign wready = !s_ff.w_got && !s_ff.bvalid;
	assign bvalid = s_ff.bvalid;
	assign bresp = s_ff.bresp;
	assign arready = !s_ff.rvalid;
	assign rvalid = s_ff.rvalid;
	assign rdata = s_ff.rdata;
	assign rresp = s_ff.rresp;
	assign primary_serial_port_baud = s_ff.live[BAUD_LSB +: BAUD_W];
	assign primary_serial_port_data8 = s_ff.live[DATA8_BIT];
	assign primary_serial_port_parity = s_ff.live[PAR_LSB +: PAR_W];
	assign primary_serial_port_stop2 = s_ff.live[STOP2_BIT];
	assign text_config_commands_en = s_ff.cmds_en;
	assign hop_active = s_ff.act;
	assign status_out = s_ff.stat;
	assign irq = s_ff.irq;

endmodule // service_mode_status_indicator

/* File: status_checker.sv */
/* status_checker: port assertions for the service and status block.
   Bound from tb; toggle counts follow the parameters handed over. */
`timescale 1ns/1ps
module status_checker
	import service_status_pkg::*;
#(
	parameter int LINK_CYC = 8,
	parameter int FAULT_CYC = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic service_n,
	input wire logic rx_frame,
	input wire logic tx_active,
	input wire logic low_power_state_one,
	input wire logic cfg_link,
	input wire logic cmd_mode,
	input wire logic fault_active,
	input wire logic [BAUD_W-1:0] primary_serial_port_baud,
	input wire logic primary_serial_port_data8,
	input wire logic [PAR_W-1:0] primary_serial_port_parity,
	input wire logic primary_serial_port_stop2,
	input wire logic text_config_commands_en,
	input wire logic status_out,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic rvalid,
	input wire logic rready
);
	logic quiet, prev_ff;
	logic [7:0] same_ff, fcnt_ff, lcnt_ff;
	assign quiet = !fault_active && !cmd_mode && !cfg_link && !tx_active;
	// run length of the status level and of the fault and link toggle causes
	always_ff @(posedge aclk) begin
		prev_ff <= status_out;
		same_ff <= (!aresetn || status_out != prev_ff) ? 8'h00 : same_ff + 8'h01;
		fcnt_ff <= (!aresetn || !fault_active) ? 8'h00 : fcnt_ff + {7'h00, fcnt_ff != 8'hFF};
		lcnt_ff <= (!aresetn || !cfg_link || fault_active || cmd_mode) ? 8'h00 : lcnt_ff + {7'h00, lcnt_ff != 8'hFF};
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_fmt_forced: assert property (!service_n |=> primary_serial_port_baud == BAUD_38400
		&& primary_serial_port_data8 && primary_serial_port_parity == 2'h0 && !primary_serial_port_stop2)
		else $error("serial format not forced");
	a_cmds_forced: assert property (!service_n |=> text_config_commands_en)
		else $error("commands not forced on");
	a_idle_high: assert property (quiet && !rx_frame && !low_power_state_one |-> ##2 status_out)
		else $error("idle level not high");
	a_rx_low: assert property (quiet && rx_frame |-> ##2 !status_out)
		else $error("receive level not low");
	a_sleep_low: assert property (quiet && !rx_frame && low_power_state_one |-> ##2 !status_out)
		else $error("sleep level not low");
	a_fault_rate: assert property (fcnt_ff > 8'(2 * FAULT_CYC + 4) |->
		(status_out != prev_ff) == (int'(same_ff) == FAULT_CYC - 1)) else $error("fault toggle rate wrong");
	a_link_rate: assert property (lcnt_ff > 8'(2 * LINK_CYC + 4) |->
		(status_out != prev_ff) == (int'(same_ff) == LINK_CYC - 1)) else $error("link toggle rate wrong");
	a_bresp_once: assert property (bvalid && bready |=> !bvalid) else $error("write response repeated");
	a_rdata_once: assert property (rvalid && rready |=> !rvalid) else $error("read data repeated");
endmodule // status_checker

/* File: terminal_model.sv */
/* terminal_model: far-side terminal of the status block.
   Drives the pulled-up service pin and types the paused plus sequence. */
`timescale 1ns/1ps
module terminal_model #(
	parameter int PAUSE = 3
) (
	input wire logic aclk,
	input wire logic svc_low,
	input wire logic enter,
	input wire logic leave,
	output logic service_n,
	output logic cmd_mode
);
	int gap, pluses;
	// released pin sits at the pull-up level
	assign service_n = svc_low ? 1'b0 : 1'b1;
	initial begin
		cmd_mode = 1'b0;
		gap = 0;
		pluses = 0;
	end
	always @(posedge aclk) begin
		if (leave) begin
			cmd_mode <= 1'b0;
			pluses = 0;
		end else if (enter && !cmd_mode) begin
			gap = gap + 1;
			if (gap > PAUSE) begin
				gap = 0;
				pluses = pluses + 1;
			end
			if (pluses == 3) begin
				cmd_mode <= 1'b1;
				pluses = 0;
			end
		end
	end
endmodule // terminal_model

/* File: tb.sv */
/* tb: self-checking bench for the service and status block.
   AXI4-Lite master tasks, terminal model, short toggle counts. */
`timescale 1ns/1ps
module tb;
	import service_status_pkg::*;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = OFF_IRQ_STS;
	localparam int LINK_CYC = 8;
	localparam int FAULT_CYC = 4;
	localparam int CC = 6;
	localparam int TC = 3;
	localparam logic [5:0] ROWS [7] = '{6'h3E, 6'h1E, 6'h0E, 6'h06, 6'h03, 6'h01, 6'h00};
	localparam int EXP [7] = '{24 / FAULT_CYC, 24 / CC, 24 / LINK_CYC, 24 / TC, 0, 0, 0};
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, hop_active;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, parity;
	logic service_n, rx_frame, tx_active, low_power_state_one, cfg_link, cmd_mode, fault_active, irq, status_out;
	logic [FAULT_CODE_W-1:0] fault_code;
	logic [BAUD_W-1:0] baud;
	logic data8, stop2, cmds_en, svc_low, enter, leave;
	int errors, n_checks;
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	service_mode_status_indicator #(.LINK_CYC(LINK_CYC), .CMD_CYC(CC), .FAULT_CYC(FAULT_CYC), .TX_CYC(TC))
	u_service_mode_status_indicator (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
		.wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
		.service_n, .rx_frame, .tx_active, .low_power_state_one, .cfg_link, .cmd_mode, .fault_active, .fault_code,
		.primary_serial_port_baud(baud), .primary_serial_port_data8(data8), .primary_serial_port_parity(parity),
		.primary_serial_port_stop2(stop2), .text_config_commands_en(cmds_en), .hop_active, .status_out, .irq);
	terminal_model #(.PAUSE(3)) u_terminal_model (.aclk, .svc_low, .enter, .leave, .service_n, .cmd_mode);
	task end_sim;
		if (errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask
	task chk1(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask
	task step(input int n);
		repeat (n) @(posedge aclk);
	endtask
	function automatic logic [31:0] live();
		return {24'h0, cmds_en, stop2, parity, data8, baud};
	endfunction
	task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid) @(posedge aclk);
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	task rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		chk(rdata, e);
		chk({30'h0, rresp}, {30'h0, er});
	endtask
	task cmd_to(input logic on);
		if (on)
			enter <= 1'b1;
		else
			leave <= 1'b1;
		@(posedge aclk);
		repeat (40) if (cmd_mode !== on) @(posedge aclk);
		enter <= 1'b0;
		leave <= 1'b0;
	endtask
	// count status edges over 24 cycles once the pattern has settled
	task pat(input int ec, input logic el, input logic lv);
		int cnt;
		logic p;
		cnt = 0;
		step(10);
		p = status_out;
		repeat (24) begin
			@(posedge aclk);
			if (status_out !== p) cnt++;
			p = status_out;
		end
		chk(32'(cnt), 32'(ec));
		if (lv) chk1(status_out, el);
	endtask
	initial begin
		{aresetn, awvalid, wvalid, arvalid, svc_low, enter, leave} = 7'h00;
		{rx_frame, tx_active, low_power_state_one, cfg_link, fault_active} = 5'h00;
		{bready, rready, wstrb} = 6'h3F;
		{awaddr, araddr, wdata, fault_code} = '0;
		errors = 0;
		n_checks = 0;
		step(16);
		aresetn <= 1'b1;
		step(1);
		rd(OFF_CFG, 32'h8A, RESP_OKAY);
		chk(live(), 32'h8A);
		chk1(status_out, 1'b1);
		wr(OFF_CFG, 32'h63, RESP_OKAY);
		wr(OFF_IRQ_EN, 32'h1, RESP_OKAY);
		step(2);
		chk(live(), 32'h63);
		svc_low <= 1'b1;
		step(4);
		chk(live(), 32'h8C);
		chk1(irq, 1'b1);
		rd(OFF_CFG, 32'h63, RESP_OKAY);
		wr(OFF_IRQ_CLR, 32'h1, RESP_OKAY);
		rd(OFF_IRQ_STATUS, 32'h0, RESP_OKAY);
		chk1(irq, 1'b0);
		svc_low <= 1'b0;
		step(4);
		chk(live(), 32'h63);
		rd(OFF_IRQ_STATUS, 32'h2, RESP_OKAY);
		chk1(irq, 1'b0);
		rd(8'h40, 32'h0, RESP_SLVERR);
		wr(8'h40, 32'h1, RESP_SLVERR);
		wr(OFF_FAULT, 32'hFF, RESP_OKAY);
		fault_code <= 8'h5A;
		wr(OFF_IRQ_CLR, 32'hF, RESP_OKAY);
		rd(OFF_FAULT, 32'h5A, RESP_OKAY);
		wr(OFF_HOP_PEND, 32'hA5A5_0001, RESP_OKAY);
		rd(OFF_HOP_ACT, 32'h0, RESP_OKAY);
		for (int i = 0; i < 7; i++) begin
			{fault_active, cfg_link, tx_active, rx_frame, low_power_state_one} <= {ROWS[i][5], ROWS[i][3:0]};
			if (cmd_mode !== ROWS[i][4]) cmd_to(ROWS[i][4]);
			pat(EXP[i], i == 6, i > 3);
		end
		chk(hop_active, 32'hA5A5_0001);
		wr(OFF_HOP_PEND, 32'hC3, RESP_OKAY);
		wr(OFF_CTRL, 32'h1, RESP_OKAY);
		rd(OFF_HOP_ACT, 32'hC3, RESP_OKAY);
		rd(OFF_IRQ_STATUS, 32'hC, RESP_OKAY);
		aresetn <= 1'b0;
		step(2);
		aresetn <= 1'b1;
		step(1);
		chk(hop_active, 32'h0);
		rd(OFF_CFG, 32'h8A, RESP_OKAY);
		cmd_to(1'b1);
		pat(0, 1'b1, 1'b1);
		end_sim;
	end
	initial begin
		step(5000);
		errors++;
		end_sim;
	end
endmodule // tb
bind service_mode_status_indicator status_checker #(.LINK_CYC(LINK_CYC), .FAULT_CYC(FAULT_CYC)) u_status_checker (
	.aclk, .aresetn, .service_n, .rx_frame, .tx_active, .low_power_state_one, .cfg_link, .cmd_mode, .fault_active,
	.primary_serial_port_baud, .primary_serial_port_data8, .primary_serial_port_parity, .primary_serial_port_stop2,
	.text_config_commands_en, .status_out, .bvalid, .bready, .rvalid, .rready);
